// ### hw/tmoc_pkg.sv
// tmoc_pkg: register offsets, field positions, reset values and encodings of the
// two-channel output compare timer.
// assumes a 32-bit apb slave with word-aligned registers.
package tmoc_pkg;
	// register byte offsets
	localparam logic [7:0] start_ofs = 8'h00;
	localparam logic [7:0] mode_ofs = 8'h04;
	localparam logic [7:0] irq_status_ofs = 8'h08;
	localparam logic [7:0] irq_enable_ofs = 8'h0c;
	localparam logic [7:0] irq_clear_ofs = 8'h10;
	localparam logic [7:0] pin_status_ofs = 8'h14;
	localparam logic [7:0] chan_base_ofs = 8'h20;
	localparam logic [7:0] chan_stride = 8'h20;
	// per-channel register offsets relative to channel base
	localparam logic [4:0] ctrl_ofs = 5'h00;
	localparam logic [4:0] pinsel_ofs = 5'h04;
	localparam logic [4:0] counter_ofs = 5'h08;
	localparam logic [4:0] cmp_a_ofs = 5'h0c;
	localparam logic [4:0] cmp_b_ofs = 5'h10;
	localparam logic [4:0] cmp_c_ofs = 5'h14;
	localparam logic [4:0] cmp_d_ofs = 5'h18;
	// start register fields: run bits at 0..1, stop-select at 2..3
	localparam int run_pos = 0;
	localparam int stop_sel_pos = 2;
	// mode register: lockstep bit
	localparam int lockstep_pos = 0;
	// channel control fields
	localparam int clk_sel_pos = 0; // 3 bits
	localparam int ext_edge_pos = 3; // 2 bits: 0 rise,1 fall,2 both
	localparam int clr_src_pos = 5; // 2 bits
	localparam int redirect_c_pos = 7;
	localparam int redirect_d_pos = 8;
	localparam int act_pos = 16; // 2 bits per pin, pins a..d
	localparam int init_pos = 24; // 1 bit per pin
	// pin select register: per pin 2 bits at 2*k: 0 port,1 compare,2 ext clock
	localparam logic [1:0] pin_port = 2'h0;
	localparam logic [1:0] pin_compare = 2'h1;
	localparam logic [1:0] pin_ext_clk = 2'h2;
	// counter clear sources
	localparam logic [1:0] clr_none = 2'h0;
	localparam logic [1:0] clr_match_a = 2'h1;
	localparam logic [1:0] clr_overflow = 2'h2;
	// output actions at match
	localparam logic [1:0] act_none = 2'h0;
	localparam logic [1:0] act_low = 2'h1;
	localparam logic [1:0] act_high = 2'h2;
	localparam logic [1:0] act_toggle = 2'h3;
	// count source selector codes
	typedef enum logic [2:0] {
		tmoc_div1_t_e = 3'h0,
		tmoc_div2_e = 3'h1,
		tmoc_div4_e = 3'h2,
		tmoc_div8_e = 3'h3,
		tmoc_div32_e = 3'h4,
		tmoc_osc_e = 3'h5,
		tmoc_ext_e = 3'h6
	} tmoc_clk_sel_t;
	// status bits per channel: match a..d at 0..3, overflow at 4; ch1 at +8
	localparam int irq_ovf_pos = 4;
	localparam int irq_chan_stride = 8;
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;
	localparam logic [15:0] cmp_reset = 16'hffff;
	localparam logic [15:0] count_zero = 16'h0000;
endpackage : tmoc_pkg

// ### hw/tmoc_timer.sv
// tmoc_timer: two-channel 16-bit output compare timer with apb register access.
// assumes pclk domain for apb; pins and oscillator tick come from outside and are
// synchronised here before use.
//
// Notes on behaviour
// - writing one to run bit starts counting
// - count source: dividers, oscillator or external edge
// - stop-select one: clearing run stops, pins hold
// - stop-select zero: stop at match a
// - interrupt on any match and overflow
// - counter read returns current count
// - lockstep off: counter write loads one channel
// - lockstep on: counter write loads both
// - compare output enabled per pin
// - match drives low, high or toggles
// - initial level until first match
// - clear on overflow or match a
// - registers c,d may steer pins a,b
// - pin a: port, compare or clock input
// - pins b..d: port or compare output
// - shared pin: cutoff or interrupt input
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module tmoc_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic onchip_fast_oscillator_clock,
	input wire logic [1:0] compare_pin_a_in,
	output logic [1:0] compare_pin_a_out,
	output logic [1:0] compare_pin_a_oe,
	output logic [1:0] compare_pin_b_out,
	output logic [1:0] compare_pin_b_oe,
	output logic [1:0] compare_pin_c_out,
	output logic [1:0] compare_pin_c_oe,
	output logic [1:0] compare_pin_d_out,
	output logic [1:0] compare_pin_d_oe,
	input wire logic shared_pin_in,
	input wire logic shared_sel_cutoff,
	output logic forced_cutoff,
	output logic external_interrupt_zero_input,
	output logic irq
);
	logic [1:0] run_reg;
	logic [1:0] stop_sel_reg;
	logic lockstep_reg;
	logic [31:0] ctrl_reg [2];
	logic [7:0] pinsel_reg [2];
	logic [15:0] count_reg [2];
	logic [15:0] cmp_reg [2][4];
	logic [3:0] pin_reg [2];
	logic [15:0] irq_status_reg;
	logic [15:0] irq_enable_reg;
	logic [4:0] prescale_reg;
	logic [1:0] ext_sync1_reg, ext_sync2_reg, ext_prev_reg;
	logic osc_sync1_reg, osc_sync2_reg, osc_prev_reg;
	logic sh_sync1_reg, sh_sync2_reg;
	logic [1:0] tick;
	logic [3:0] match [2];
	logic [1:0] ovf;
	logic [15:0] irq_set;
	logic wr_acc, rd_acc;
	logic [1:0] chan_hit;
	logic [4:0] chan_ofs;
	logic [1:0] cnt_wr;

	// decode a register address; returns 1 when inside that channel window
	function automatic logic in_chan(input logic [7:0] a, input int ch);
		logic [7:0] base;
		base = 8'(tmoc_pkg::chan_base_ofs + 8'(ch) * tmoc_pkg::chan_stride);
		return (a >= base) && (a < 8'(base + tmoc_pkg::chan_stride));
	endfunction : in_chan

	// next pin level for one action code
	function automatic logic pin_action(input logic [1:0] act, input logic cur);
		unique case (act)
			tmoc_pkg::act_low: return 1'b0;
			tmoc_pkg::act_high: return 1'b1;
			tmoc_pkg::act_toggle: return ~cur;
			default: return cur;
		endcase
	endfunction : pin_action

	assign wr_acc = psel & penable & pwrite & clk_en;
	assign rd_acc = psel & penable & ~pwrite & clk_en;
	assign chan_ofs = paddr[4:0];

	// pin and oscillator synchronisers; first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_sync1_reg <= 2'h0;
			ext_sync2_reg <= 2'h0;
			osc_sync1_reg <= 1'b0;
			osc_sync2_reg <= 1'b0;
			sh_sync1_reg <= 1'b0;
			sh_sync2_reg <= 1'b0;
		end else if (clk_en) begin
			ext_sync1_reg <= compare_pin_a_in;
			ext_sync2_reg <= ext_sync1_reg;
			osc_sync1_reg <= onchip_fast_oscillator_clock;
			osc_sync2_reg <= osc_sync1_reg;
			sh_sync1_reg <= shared_pin_in;
			sh_sync2_reg <= sh_sync1_reg;
		end
	end

	// edge history and free-running prescaler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev_reg <= 2'h0;
			osc_prev_reg <= 1'b0;
			prescale_reg <= 5'h00;
		end else if (clk_en) begin
			ext_prev_reg <= ext_sync2_reg;
			osc_prev_reg <= osc_sync2_reg;
			prescale_reg <= 5'(prescale_reg + 5'h01);
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			logic rise, fall;
			logic [1:0] edge_sel;
			rise = ext_sync2_reg[c] & ~ext_prev_reg[c];
			fall = ~ext_sync2_reg[c] & ext_prev_reg[c];
			edge_sel = ctrl_reg[c][tmoc_pkg::ext_edge_pos +: 2];
			unique case (ctrl_reg[c][tmoc_pkg::clk_sel_pos +: 3])
				3'h0: tick[c] = 1'b1;
				3'h1: tick[c] = prescale_reg[0];
				3'h2: tick[c] = &prescale_reg[1:0];
				3'h3: tick[c] = &prescale_reg[2:0];
				3'h4: tick[c] = &prescale_reg[4:0];
				3'h5: tick[c] = osc_sync2_reg & ~osc_prev_reg;
				3'h6: tick[c] = (pinsel_reg[c][1:0] == tmoc_pkg::pin_ext_clk) &
					(edge_sel == 2'h0 ? rise : edge_sel == 2'h1 ? fall : (rise | fall));
				default: tick[c] = 1'b0;
			endcase
			tick[c] = tick[c] & run_reg[c];
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			for (int k = 0; k < 4; k++)
				match[c][k] = tick[c] & (count_reg[c] == cmp_reg[c][k]);
			ovf[c] = tick[c] & (count_reg[c] == 16'hffff);
		end
	end

	always_comb begin
		irq_set = 16'h0000;
		for (int c = 0; c < 2; c++) begin
			irq_set[c * tmoc_pkg::irq_chan_stride +: 4] = match[c];
			irq_set[c * tmoc_pkg::irq_chan_stride + tmoc_pkg::irq_ovf_pos] = ovf[c];
		end
	end

	assign cnt_wr[0] = wr_acc & in_chan(paddr, 0) & (chan_ofs == tmoc_pkg::counter_ofs);
	assign cnt_wr[1] = wr_acc & in_chan(paddr, 1) & (chan_ofs == tmoc_pkg::counter_ofs);
	assign chan_hit[0] = in_chan(paddr, 0);
	assign chan_hit[1] = in_chan(paddr, 1);

	// counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg[0] <= tmoc_pkg::count_zero;
			count_reg[1] <= tmoc_pkg::count_zero;
		end else if (clk_en) begin
			for (int c = 0; c < 2; c++) begin
				if (lockstep_reg && |cnt_wr)
					count_reg[c] <= pwdata[15:0];
				else if (!lockstep_reg && cnt_wr[c])
					count_reg[c] <= pwdata[15:0];
				else if (match[c][0] && ctrl_reg[c][tmoc_pkg::clr_src_pos +: 2] == tmoc_pkg::clr_match_a)
					count_reg[c] <= tmoc_pkg::count_zero;
				else if (tick[c])
					count_reg[c] <= 16'(count_reg[c] + 16'h0001); // wraps to zero on overflow
			end
		end
	end

	// run and stop-select control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= 2'h0;
			stop_sel_reg <= 2'h0;
		end else if (clk_en) begin
			for (int c = 0; c < 2; c++) begin
				if (wr_acc && paddr == tmoc_pkg::start_ofs) begin
					if (pwdata[tmoc_pkg::run_pos + c] || stop_sel_reg[c])
						run_reg[c] <= pwdata[tmoc_pkg::run_pos + c];
					stop_sel_reg[c] <= pwdata[tmoc_pkg::stop_sel_pos + c];
				end else if (!stop_sel_reg[c] && match[c][0]) begin
					run_reg[c] <= 1'b0;
				end
			end
		end
	end

	// pin levels; hold across stops since only matches and a start write move them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_reg[0] <= 4'h0;
			pin_reg[1] <= 4'h0;
		end else if (clk_en) begin
			for (int c = 0; c < 2; c++) begin
				if (wr_acc && paddr == tmoc_pkg::start_ofs && pwdata[tmoc_pkg::run_pos + c] && !run_reg[c]) begin
					pin_reg[c] <= ctrl_reg[c][tmoc_pkg::init_pos +: 4];
				end else begin
					for (int k = 0; k < 4; k++) begin
						logic hit;
						hit = match[c][k];
						// c and d redirect to a and b
						if (k == 0 && ctrl_reg[c][tmoc_pkg::redirect_c_pos])
							hit = match[c][0] | match[c][2];
						if (k == 1 && ctrl_reg[c][tmoc_pkg::redirect_d_pos])
							hit = match[c][1] | match[c][3];
						if (k >= 2 && ctrl_reg[c][tmoc_pkg::redirect_c_pos + k - 2])
							hit = 1'b0;
						if (hit)
							pin_reg[c][k] <= pin_action(ctrl_reg[c][tmoc_pkg::act_pos + 2 * k +: 2], pin_reg[c][k]);
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compare_pin_a_out <= 2'h0;
			compare_pin_b_out <= 2'h0;
			compare_pin_c_out <= 2'h0;
			compare_pin_d_out <= 2'h0;
			compare_pin_a_oe <= 2'h0;
			compare_pin_b_oe <= 2'h0;
			compare_pin_c_oe <= 2'h0;
			compare_pin_d_oe <= 2'h0;
		end else if (clk_en) begin
			for (int c = 0; c < 2; c++) begin
				compare_pin_a_out[c] <= pin_reg[c][0];
				compare_pin_b_out[c] <= pin_reg[c][1];
				compare_pin_c_out[c] <= pin_reg[c][2];
				compare_pin_d_out[c] <= pin_reg[c][3];
				compare_pin_a_oe[c] <= pinsel_reg[c][1:0] == tmoc_pkg::pin_compare;
				compare_pin_b_oe[c] <= pinsel_reg[c][3:2] == tmoc_pkg::pin_compare;
				compare_pin_c_oe[c] <= pinsel_reg[c][5:4] == tmoc_pkg::pin_compare;
				compare_pin_d_oe[c] <= pinsel_reg[c][7:6] == tmoc_pkg::pin_compare;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			forced_cutoff <= 1'b0;
			external_interrupt_zero_input <= 1'b0;
		end else if (clk_en) begin
			forced_cutoff <= shared_sel_cutoff & sh_sync2_reg;
			external_interrupt_zero_input <= ~shared_sel_cutoff & sh_sync2_reg;
		end
	end

	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lockstep_reg <= 1'b0;
			irq_enable_reg <= 16'h0000;
			for (int c = 0; c < 2; c++) begin
				ctrl_reg[c] <= tmoc_pkg::ctrl_reset;
				pinsel_reg[c] <= 8'h00;
				for (int k = 0; k < 4; k++)
					cmp_reg[c][k] <= tmoc_pkg::cmp_reset;
			end
		end else if (clk_en && wr_acc) begin
			if (paddr == tmoc_pkg::mode_ofs)
				lockstep_reg <= pwdata[tmoc_pkg::lockstep_pos];
			if (paddr == tmoc_pkg::irq_enable_ofs)
				irq_enable_reg <= pwdata[15:0];
			for (int c = 0; c < 2; c++) begin
				if (chan_hit[c]) begin
					unique case (chan_ofs)
						tmoc_pkg::ctrl_ofs: ctrl_reg[c] <= pwdata;
						tmoc_pkg::pinsel_ofs: pinsel_reg[c] <= pwdata[7:0];
						tmoc_pkg::cmp_a_ofs: cmp_reg[c][0] <= pwdata[15:0];
						tmoc_pkg::cmp_b_ofs: cmp_reg[c][1] <= pwdata[15:0];
						tmoc_pkg::cmp_c_ofs: cmp_reg[c][2] <= pwdata[15:0];
						tmoc_pkg::cmp_d_ofs: cmp_reg[c][3] <= pwdata[15:0];
						default: ;
					endcase
				end
			end
		end
	end

	// sticky status: a set in the clear cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_status_reg <= 16'h0000;
		else if (clk_en) begin
			if (wr_acc && paddr == tmoc_pkg::irq_clear_ofs)
				irq_status_reg <= (irq_status_reg & ~pwdata[15:0]) | irq_set;
			else
				irq_status_reg <= irq_status_reg | irq_set;
		end
	end

	// interrupt output is registered, so it lags status by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(irq_status_reg & irq_enable_reg);
	end

	// apb answers in the access cycle; read data registered at the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				if (paddr == tmoc_pkg::start_ofs)
					prdata <= {28'h0, stop_sel_reg, run_reg};
				else if (paddr == tmoc_pkg::mode_ofs)
					prdata <= {31'h0, lockstep_reg};
				else if (paddr == tmoc_pkg::irq_status_ofs)
					prdata <= {16'h0, irq_status_reg};
				else if (paddr == tmoc_pkg::irq_enable_ofs)
					prdata <= {16'h0, irq_enable_reg};
				else if (paddr == tmoc_pkg::pin_status_ofs)
					prdata <= {24'h0, pin_reg[1], pin_reg[0]};
				for (int c = 0; c < 2; c++) begin
					if (chan_hit[c]) begin
						unique case (chan_ofs)
							tmoc_pkg::ctrl_ofs: prdata <= ctrl_reg[c];
							tmoc_pkg::pinsel_ofs: prdata <= {24'h0, pinsel_reg[c]};
							tmoc_pkg::counter_ofs: prdata <= {16'h0, count_reg[c]};
							tmoc_pkg::cmp_a_ofs: prdata <= {16'h0, cmp_reg[c][0]};
							tmoc_pkg::cmp_b_ofs: prdata <= {16'h0, cmp_reg[c][1]};
							tmoc_pkg::cmp_c_ofs: prdata <= {16'h0, cmp_reg[c][2]};
							tmoc_pkg::cmp_d_ofs: prdata <= {16'h0, cmp_reg[c][3]};
							default: ;
						endcase
					end
				end
			end
		end
	end
endmodule : tmoc_timer

// ### tb/tmoc_timer_assertions.sv
// tmoc_timer_assertions: port-level checks of the output compare timer.
// assumes the pclk domain only; bound to every tmoc_timer instance.
`timescale 1ns/10ps
module tmoc_timer_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] compare_pin_a_out,
	input wire logic [1:0] compare_pin_b_oe,
	input wire logic shared_pin_in,
	input wire logic shared_sel_cutoff,
	input wire logic forced_cutoff,
	input wire logic external_interrupt_zero_input,
	input wire logic irq
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// apb answer: one cycle, only in an access cycle
	// a frozen clock enable holds pready, so only a running cycle must drop it
	pready_pulse_a: assert property (pready && clk_en |=> !pready)
		else $error("pready longer than one cycle");
	pready_phase_a: assert property (pready |-> psel && penable)
		else $error("pready outside access cycle");
	access_answer_a: assert property (psel && !penable && clk_en ##1 penable && clk_en |-> pready)
		else $error("no answer in first access cycle");
	no_error_a: assert property (pready |-> !pslverr)
		else $error("unexpected slave error");
	// a frozen clock enable must leave pin a output and request still
	frozen_hold_a: assert property (!clk_en |=> $stable(compare_pin_a_out) && $stable(irq))
		else $error("pins moved while frozen");
	// shared pin routing, allowing for the synchroniser delay
	cutoff_route_a: assert property ((clk_en && shared_sel_cutoff && shared_pin_in) [*5] |-> forced_cutoff)
		else $error("cutoff input not routed");
	intr_route_a: assert property ((clk_en && !shared_sel_cutoff && shared_pin_in) [*5]
		|-> external_interrupt_zero_input && !forced_cutoff)
		else $error("interrupt input not routed");
	oe_after_write_a: assert property ($changed(compare_pin_b_oe)
		|-> $past(pwrite && pready) || $past(pwrite && pready, 2))
		else $error("pin enable changed without a write");
	cover property ($rose(irq));
	cover property ($changed(compare_pin_a_out));
	cover property (pready && !pwrite);
endmodule : tmoc_timer_assertions

bind tmoc_timer tmoc_timer_assertions chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .compare_pin_a_out(compare_pin_a_out),
	.compare_pin_b_oe(compare_pin_b_oe), .shared_pin_in(shared_pin_in), .shared_sel_cutoff(shared_sel_cutoff),
	.forced_cutoff(forced_cutoff), .external_interrupt_zero_input(external_interrupt_zero_input), .irq(irq));

// ### tb/timer_output_compare_mode_tb_top.sv
// timer_output_compare_mode_tb_top: self-checking bench of the compare timer.
// assumes single-cycle apb answers; channel 0 counts on the undivided tick.
`timescale 1ns/10ps
module timer_output_compare_mode_tb_top;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic osc = 0, shin = 0, shsel = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [1:0] ain = 2'h0;
	logic [63:0] e;
	logic [63:0] q[$];
	logic [15:0] v;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, fcut, eint, irq;
	wire logic [1:0] ao, aoe, bo, boe, co, coe, dout, doe;
	int num_errors = 0, checks = 0, cyc = 0;

	tmoc_timer uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.onchip_fast_oscillator_clock(osc), .compare_pin_a_in(ain), .compare_pin_a_out(ao),
		.compare_pin_a_oe(aoe), .compare_pin_b_out(bo), .compare_pin_b_oe(boe), .compare_pin_c_out(co),
		.compare_pin_c_oe(coe), .compare_pin_d_out(dout), .compare_pin_d_oe(doe), .shared_pin_in(shin),
		.shared_sel_cutoff(shsel), .forced_cutoff(fcut), .external_interrupt_zero_input(eint), .irq(irq));

	// 4 ns clock
	initial forever #2 pclk = ~pclk;

	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			num_errors++;
			$display("[FAIL] %s exp %h seen %h", n, x, s);
		end
	endtask : chk

	task finish_test;
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// one apb transfer; a read notes its expected word and mask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hffffffff);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr)
			q.push_back({m, d});
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle

	// read monitor: oldest note against the answer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = q.pop_front();
			chk("prdata", prdata & e[63:32], e[31:0]);
		end
	end

	// hang guard, far above the roughly 550 cycles needed
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	// oscillator tick and noise on pin a inputs
	always @(posedge pclk) begin
		osc <= ~osc;
		ain <= 2'($urandom);
	end

	initial begin
		void'($urandom(32'heb21d84e));
		idle(3);
		presetn <= 1'b1;
		// reset value and an unmapped place
		apb(0, 8'h2c, 32'hffff);
		apb(1, 8'hfc, 32'h1);
		apb(0, 8'hfc, 32'h0);
		// shared pin: cutoff then interrupt
		shin <= 1'b1;
		shsel <= 1'b1;
		idle(8);
		chk("cutoff", fcut, 1);
		shsel <= 1'b0;
		idle(8);
		chk("int0", {fcut, eint}, 2'b01);
		// counter writes with lockstep off, then on
		v = 16'($urandom);
		apb(1, 8'h04, 0);
		apb(1, 8'h28, v);
		apb(0, 8'h28, v);
		apb(0, 8'h48, 0);
		apb(1, 8'h04, 1);
		apb(1, 8'h48, ~v);
		apb(0, 8'h28, {16'h0, ~v});
		// channel 0: b high, c low, a toggles, d idle; period 41
		apb(1, 8'h24, 32'h55);
		apb(1, 8'h20, 32'h0c1b0020);
		apb(1, 8'h2c, 40);
		apb(1, 8'h30, 10);
		apb(1, 8'h34, 20);
		apb(1, 8'h38, 30);
		apb(1, 8'h28, 0);
		apb(1, 8'h0c, 32'hf);
		apb(1, 8'h10, 32'hffff);
		apb(1, 8'h00, 32'h5);
		idle(3);
		chk("init", {bo[0], co[0], boe[0], aoe[0]}, 4'b0111);
		idle(50);
		clk_en <= 1'b0;
		idle(5);
		clk_en <= 1'b1;
		idle(50);
		chk("match", {bo[0], co[0], irq}, 3'b101);
		apb(0, 8'h08, 32'hf, 32'h1f);
		// mask then unmask the request
		apb(1, 8'h0c, 0);
		idle(2);
		chk("masked", irq, 0);
		apb(1, 8'h0c, 32'hf);
		idle(2);
		chk("unmasked", irq, 1);
		// stop by run bit: no new events, pins hold
		apb(1, 8'h00, 32'h4);
		apb(1, 8'h10, 32'hff);
		idle(60);
		apb(0, 8'h08, 0, 32'h1f);
		chk("held", {bo[0], co[0], irq}, 3'b100);
		// stop-select zero: halts itself at match a
		apb(1, 8'h28, 0);
		apb(1, 8'h00, 32'h1);
		idle(100);
		apb(1, 8'h10, 32'hff);
		idle(60);
		apb(0, 8'h08, 0, 32'h1f);
		// clear on overflow from near the top
		apb(1, 8'h00, 0);
		apb(1, 8'h20, 32'h0c1b0040);
		apb(1, 8'h28, 32'hfff0);
		apb(1, 8'h10, 32'hff);
		apb(1, 8'h00, 32'h5);
		idle(40);
		apb(0, 8'h08, 32'h10, 32'h10);
		// c steers pin a, d steers pin b; pins c and d then stay at their initial level
		apb(1, 8'h00, 0);
		apb(1, 8'h20, 32'h00af01a0);
		apb(1, 8'h28, 0);
		apb(1, 8'h00, 32'h5);
		idle(35);
		chk("redirect", {ao[0], bo[0], co[0], dout[0]}, 4'b1000);
		chk("oe_cd", {coe[0], doe[0]}, 2'b11);
		finish_test();
	end
endmodule : timer_output_compare_mode_tb_top
